// File: stm_defs.svh
// Register offsets, field positions, reset values and timing counts for the timer
`ifndef STM_DEFS_SVH
`define STM_DEFS_SVH

// ==========================================
// Register byte offsets
`define STM_OFS_CTRL0    12'h000
`define STM_OFS_CTRL1    12'h004
`define STM_OFS_CNT      12'h008
`define STM_OFS_CMPA     12'h00c
`define STM_OFS_PERIOD   12'h010
`define STM_OFS_FLAGS    12'h014

// ==========================================
// Control zero fields
`define STM_C0_ENABLE    3

// ==========================================
// Control one fields
`define STM_C1_MODE_HI   7
`define STM_C1_MODE_LO   6
`define STM_C1_PIN_HI    5
`define STM_C1_PIN_LO    4
`define STM_C1_INIT      3
`define STM_C1_POL       2
`define STM_C1_SWAP      1
`define STM_C1_CLR       0

// ==========================================
// Flag register fields
`define STM_FL_A         0
`define STM_FL_P         1
`define STM_FL_CAP       2

// ==========================================
// Reset values
`define STM_RST_CTRL0    8'h00
`define STM_RST_CTRL1    8'h00
`define STM_RST_PERIOD   8'h00
`define STM_RST_CMPA     16'h0000

// ==========================================
// Timing counts
`define STM_PERIOD_UNIT  17'h00100
`define STM_FULL_PERIOD  17'h10000

`endif

// File: stm_pkg.sv
// Types shared by the timer modules
package stm_pkg;

  typedef enum logic [1:0] {
    STM_MODE_CMP = 2'b00,
    STM_MODE_CAP = 2'b01,
    STM_MODE_PWM = 2'b10,
    STM_MODE_TMR = 2'b11
  } stm_mode_e;

  typedef enum logic [1:0] {
    STM_PA_0 = 2'b00,
    STM_PA_1 = 2'b01,
    STM_PA_2 = 2'b10,
    STM_PA_3 = 2'b11
  } stm_pin_action_e;

endpackage

// File: stm_cfg_if.sv
// Configuration and event bundle between the register file and the counter core
interface stm_cfg_if;
  import stm_pkg::*;

  stm_mode_e       operating_mode_select;
  stm_pin_action_e pin_action_select;
  logic            initial_level_control;
  logic            duty_period_swap;
  logic            counter_clear_source;
  logic            counter_enable;
  logic [15:0]     compare_a_value;
  logic [7:0]      period_compare_byte;
  logic [15:0]     count;
  logic            match_a;
  logic            match_p;
  logic            capture_evt;
  logic [15:0]     capture_val;
  logic            raw_out;

  modport regs (
    output operating_mode_select, pin_action_select, initial_level_control,
    output duty_period_swap, counter_clear_source, counter_enable,
    output compare_a_value, period_compare_byte,
    input  count, match_a, match_p, capture_evt, capture_val, raw_out
  );
  modport core (
    input  operating_mode_select, pin_action_select, initial_level_control,
    input  duty_period_swap, counter_clear_source, counter_enable,
    input  compare_a_value, period_compare_byte,
    output count, match_a, match_p, capture_evt, capture_val, raw_out
  );
endinterface

// File: stm_core.sv
// Counter, comparators, capture edge detect and output waveform
`include "stm_defs.svh"

module stm_core
  import stm_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic cap_in_sync,
  stm_cfg_if.core   cfg
);

  // ==========================================
  // Enable edge detect
  logic        en_prev_q, en_prev_d;
  logic        en_rise;
  logic [15:0] cnt_q, cnt_d;
  logic        out_q, out_d;
  logic        cap_prev_q, cap_prev_d;
  logic        hit_a, hit_p, cap_hit;
  logic [16:0] period_len, duty_len, cnt_next;
  logic [16:0] period_compare_value_len;

  assign en_rise = cfg.counter_enable & ~en_prev_q;

  // ==========================================
  // Comparators
  always_comb begin
    cnt_next = {1'b0, cnt_q} + 17'h00001;
    period_compare_value_len = (cfg.period_compare_byte == 8'h00) ? `STM_FULL_PERIOD  // RL12
             : {1'b0, cfg.period_compare_byte, 8'h00};
    // Matches fire as the count reaches the programmed value
    hit_a = cfg.counter_enable & ~en_rise & (cnt_next == {1'b0, cfg.compare_a_value}); // RL24
    hit_p = cfg.counter_enable & ~en_rise & (cnt_next == period_compare_value_len);  // RL12
    if (cfg.duty_period_swap) begin  // RL10 RL20
      period_len = {1'b0, cfg.compare_a_value};
      duty_len   = period_compare_value_len;
    end else begin  // RL19
      period_len = period_compare_value_len;
      duty_len   = {1'b0, cfg.compare_a_value};
    end
    cap_hit = 1'b0;
    case (cfg.pin_action_select)  // RL6
      STM_PA_0: cap_hit = cap_in_sync & ~cap_prev_q;
      STM_PA_1: cap_hit = ~cap_in_sync & cap_prev_q;
      STM_PA_2: cap_hit = cap_in_sync ^ cap_prev_q;
      default:  cap_hit = 1'b0;
    endcase
    cap_hit = cap_hit & cfg.counter_enable
            & (cfg.operating_mode_select == STM_MODE_CAP);
  end

  // ==========================================
  // Counter and output state
  always_comb begin
    en_prev_d  = cfg.counter_enable;
    cap_prev_d = cap_in_sync;
    cnt_d      = cnt_q;
    out_d      = out_q;
    if (en_rise) begin
      cnt_d = 16'h0000;  // RL23
      out_d = cfg.initial_level_control;  // RL4
    end else if (cfg.counter_enable) begin
      cnt_d = cnt_next[15:0];  // RL24
      case (cfg.operating_mode_select)
        STM_MODE_PWM: begin
          // Counter cleared by the period comparator
          if (cnt_next >= period_len) begin  // RL18
            cnt_d = 16'h0000;
          end
        end
        STM_MODE_CAP: begin
          if (hit_p) begin
            cnt_d = 16'h0000;
          end
        end
        default: begin
          if (cfg.counter_clear_source ? hit_a : hit_p) begin  // RL11
            cnt_d = 16'h0000;
          end
          // Only comparator A moves the pin
          if (hit_a && cfg.operating_mode_select == STM_MODE_CMP) begin  // RL16
            case (cfg.pin_action_select)  // RL2 RL3
              STM_PA_1: out_d = 1'b0;
              STM_PA_2: out_d = 1'b1;
              STM_PA_3: out_d = ~out_q;
              default:  out_d = out_q;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_prev_q  <= 1'b0;
      cap_prev_q <= 1'b0;
      cnt_q      <= 16'h0000;
      out_q      <= 1'b0;
    end else begin
      en_prev_q  <= en_prev_d;
      cap_prev_q <= cap_prev_d;
      cnt_q      <= cnt_d;
      out_q      <= out_d;
    end
  end

  // ==========================================
  // Waveform before polarity
  logic pwm_active;
  always_comb begin
    // Duty at or above the period keeps the output active throughout
    pwm_active = ({1'b0, cnt_q} < duty_len) || (duty_len >= period_len);  // RL21
    cfg.raw_out = out_q;
    if (cfg.operating_mode_select == STM_MODE_PWM) begin
      case (cfg.pin_action_select)  // RL5 RL8
        STM_PA_0: cfg.raw_out = ~cfg.initial_level_control;
        STM_PA_1: cfg.raw_out = cfg.initial_level_control;
        STM_PA_2: cfg.raw_out = pwm_active ~^ cfg.initial_level_control;
        default:  cfg.raw_out = cfg.counter_enable ~^ cfg.initial_level_control;
      endcase
    end
  end

  assign cfg.count       = cnt_q;
  assign cfg.match_a     = hit_a;
  assign cfg.match_p     = hit_p;
  assign cfg.capture_evt = cap_hit;
  assign cfg.capture_val = cnt_q;

endmodule

// File: stm_timer.sv
// Standard timer top: APB register file, pin synchroniser, flags and output pin
//
// Functional notes
// RL1 - Two-bit mode field selects operating mode
// RL2 - Compare A match applies pin action
// RL3 - No change when requested level equals initial
// RL4 - Enable rising edge restores initial level
// RL5 - PWM pin action: inactive, active, PWM, pulse
// RL6 - Capture pin action selects trigger edge
// RL7 - Software changes pin action only when stopped
// RL8 - Initial level bit sets level or activity
// RL9 - Polarity bit inverts output pin
// RL10 - Swap bit exchanges PWM duty and period
// RL11 - Clear source: A match, else P/overflow
// RL12 - Period byte matches counter bits 15..8
// RL13 - Compare mode, clear P: both flags
// RL14 - Compare mode, clear A: A flag only
// RL15 - Software never programs compare A zero
// RL16 - Only comparator A changes the pin
// RL17 - Timer mode like compare, pin released
// RL18 - PWM flags both; period comparator clears
// RL19 - Swap zero: period byte period, A duty
// RL20 - Swap one: A period, byte duty
// RL21 - Duty at or beyond period: always active
// RL22 - PWM counting continues while output forced
// RL23 - Enable rise clears; fall holds count
// RL24 - Sixteen-bit up counter, A compares all
// RL25 - Flags stay set until software clears
`include "stm_defs.svh"

module stm_timer
  import stm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        capture_input_pin,
  output logic             timer_output_pin,
  output logic             timer_output_pin_oe
);

  stm_cfg_if cfg ();

  // ==========================================
  // Capture pin synchroniser
  logic cap_s1_q, cap_s2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_s1_q <= 1'b0;
      cap_s2_q <= 1'b0;
    end else begin
      cap_s1_q <= capture_input_pin;
      cap_s2_q <= cap_s1_q;
    end
  end

  stm_core u_core (
    .pclk        (pclk),
    .presetn     (presetn),
    .cap_in_sync (cap_s2_q),
    .cfg         (cfg.core)
  );

  // ==========================================
  // Registers
  logic [7:0]  ctrl0_q, ctrl0_d;
  logic [7:0]  ctrl1_q, ctrl1_d;
  logic [15:0] cmpa_q, cmpa_d;
  logic [7:0]  period_q, period_d;
  logic [2:0]  flags_q, flags_d;
  logic [31:0] rdata_q, rdata_d;
  logic        wr_en, rd_en, addr_ok;
  logic [2:0]  flag_set, flag_clr;
  stm_mode_e   mode;

  assign wr_en = psel & penable & pwrite;
  // Read data latched in setup so it stands through the access phase
  assign rd_en = psel & ~penable & ~pwrite;
  assign mode  = stm_mode_e'(ctrl1_q[`STM_C1_MODE_HI:`STM_C1_MODE_LO]);  // RL1

  always_comb begin
    addr_ok = 1'b1;
    if (paddr == `STM_OFS_CTRL0) begin
      rdata_d = {24'h000000, ctrl0_q[7:3], 3'h0};
    end else if (paddr == `STM_OFS_CTRL1) begin
      rdata_d = {24'h000000, ctrl1_q};
    end else if (paddr == `STM_OFS_CNT) begin
      rdata_d = {16'h0000, cfg.count};
    end else if (paddr == `STM_OFS_CMPA) begin
      rdata_d = {16'h0000, cmpa_q};
    end else if (paddr == `STM_OFS_PERIOD) begin
      rdata_d = {24'h000000, period_q};
    end else if (paddr == `STM_OFS_FLAGS) begin
      rdata_d = {29'h0, flags_q};
    end else begin
      rdata_d = 32'h00000000;
      addr_ok = 1'b0;
    end
    if (!rd_en) begin
      rdata_d = rdata_q;
    end
  end

  always_comb begin
    ctrl0_d  = ctrl0_q;
    ctrl1_d  = ctrl1_q;
    cmpa_d   = cmpa_q;
    period_d = period_q;
    flag_clr = 3'h0;
    if (wr_en && pstrb[0]) begin
      if (paddr == `STM_OFS_CTRL0) begin
        ctrl0_d = {pwdata[7:3], 3'h0};
      end else if (paddr == `STM_OFS_CTRL1) begin
        ctrl1_d = pwdata[7:0];
      end else if (paddr == `STM_OFS_PERIOD) begin
        period_d = pwdata[7:0];
      end else if (paddr == `STM_OFS_FLAGS) begin
        flag_clr = pwdata[2:0];
      end
    end
    if (wr_en && paddr == `STM_OFS_CMPA) begin
      if (pstrb[0]) begin
        cmpa_d[7:0] = pwdata[7:0];
      end
      if (pstrb[1]) begin
        cmpa_d[15:8] = pwdata[15:8];
      end
    end
    // Capture overwrites compare A with the live count
    if (cfg.capture_evt) begin  // RL6
      cmpa_d = cfg.capture_val;
    end
  end

  // ==========================================
  // Match flags
  always_comb begin
    flag_set = 3'h0;
    case (mode)
      STM_MODE_CMP, STM_MODE_TMR: begin  // RL17
        flag_set[`STM_FL_A] = cfg.match_a;  // RL13
        flag_set[`STM_FL_P] = cfg.match_p & ~ctrl1_q[`STM_C1_CLR];  // RL14
      end
      STM_MODE_PWM: begin  // RL18 RL22
        flag_set[`STM_FL_A] = cfg.match_a;
        flag_set[`STM_FL_P] = cfg.match_p;
      end
      default: begin
        flag_set[`STM_FL_P]   = cfg.match_p;
        flag_set[`STM_FL_CAP] = cfg.capture_evt;
      end
    endcase
    // Set wins over a same-cycle clear
    flags_d = (flags_q & ~flag_clr) | flag_set;  // RL25
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_q  <= `STM_RST_CTRL0;
      ctrl1_q  <= `STM_RST_CTRL1;
      cmpa_q   <= `STM_RST_CMPA;
      period_q <= `STM_RST_PERIOD;
      flags_q  <= 3'h0;
      rdata_q  <= 32'h00000000;
    end else begin
      ctrl0_q  <= ctrl0_d;
      ctrl1_q  <= ctrl1_d;
      cmpa_q   <= cmpa_d;
      period_q <= period_d;
      flags_q  <= flags_d;
      rdata_q  <= rdata_d;
    end
  end

  // ==========================================
  // Configuration to the core
  assign cfg.operating_mode_select = mode;
  assign cfg.pin_action_select     = stm_pin_action_e'(ctrl1_q[`STM_C1_PIN_HI:`STM_C1_PIN_LO]);
  assign cfg.initial_level_control = ctrl1_q[`STM_C1_INIT];
  assign cfg.duty_period_swap      = ctrl1_q[`STM_C1_SWAP];
  assign cfg.counter_clear_source  = ctrl1_q[`STM_C1_CLR];
  assign cfg.counter_enable        = ctrl0_q[`STM_C0_ENABLE];
  assign cfg.compare_a_value       = cmpa_q;
  assign cfg.period_compare_byte   = period_q;

  // ==========================================
  // Bus answer, zero wait states
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata  = rdata_q;

  // ==========================================
  // Output pin; registered to keep glitches off the pin
  logic pin_q, pin_d, oe_q, oe_d;
  always_comb begin
    pin_d = cfg.raw_out ^ ctrl1_q[`STM_C1_POL];  // RL9
    // Timer mode and capture mode release the pin
    oe_d  = (mode == STM_MODE_CMP) || (mode == STM_MODE_PWM);  // RL17
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      pin_q <= pin_d;
      oe_q  <= oe_d;
    end
  end

  assign timer_output_pin    = pin_q;
  assign timer_output_pin_oe = oe_q;

endmodule

// File: stm_load.sv
// Far-side model: capture signal source and load on the timer output pin
module stm_load (
  input  wire logic        pclk,
  input  wire logic        pin,
  input  wire logic        oe,
  output logic             cap,
  output logic [15:0]      hi_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Load and source
  initial cap = 1'b0;
  initial hi_cnt = 16'h0;
  // Only driven cycles count; a released pin carries no level
  always @(posedge pclk) if (oe && pin) hi_cnt <= hi_cnt + 16'h1;
  task automatic set_cap(input logic v);
    @(posedge pclk);
    cap <= v;
  endtask
endmodule

// File: stm_timer_checker.sv
// Concurrent checks on the timer top-level ports
`include "stm_defs.svh"
module stm_timer_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        capture_input_pin,
  input wire logic        timer_output_pin,
  input wire logic        timer_output_pin_oe
);
  // ==========
  // Shadow of control bits
  logic [7:0] c1_q, c1_d;
  logic       en_q, en_d;
  logic [2:0] qt_q, qt_d;
  logic       wr0, wr1, quiet;
  assign wr0 = psel && penable && pwrite && pstrb[0] && paddr == `STM_OFS_CTRL0;
  assign wr1 = psel && penable && pwrite && pstrb[0] && paddr == `STM_OFS_CTRL1;
  // Pin needs a few cycles to settle after any control write
  assign quiet = qt_q == 3'h4;
  always_comb begin
    c1_d = wr1 ? pwdata[7:0] : c1_q;
    en_d = wr0 ? pwdata[3] : en_q;
    qt_d = (wr0 || wr1) ? 3'h0 : qt_q + {2'h0, !quiet};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_q <= 8'h0;
      en_q <= 1'b0;
      qt_q <= 3'h0;
    end else begin
      c1_q <= c1_d;
      en_q <= en_d;
      qt_q <= qt_d;
    end
  end
  // ==========
  // Assertions
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_oe_timer: assert property (quiet && c1_q[7:6] == 2'b11 |-> !timer_output_pin_oe)
    else $error("pin driven in timer mode");
  chk_oe_drive: assert property (quiet && c1_q[7:6] == 2'b00 |-> timer_output_pin_oe)
    else $error("pin not driven in compare mode");
  chk_init_level: assert property (wr0 && pwdata[3] && !en_q && c1_q[7:6] == 2'b00
    |=> ##[0:2] timer_output_pin == (c1_q[3] ^ c1_q[2])) else $error("initial level wrong");
  chk_pwm_inact: assert property (quiet && en_q && c1_q[7:4] == 4'b1000
    |-> timer_output_pin == (!c1_q[3] ^ c1_q[2])) else $error("forced inactive wrong");
  chk_pwm_act: assert property (quiet && en_q && c1_q[7:4] == 4'b1001
    |-> timer_output_pin == (c1_q[3] ^ c1_q[2])) else $error("forced active wrong");
  chk_cmp_hold: assert property (quiet && c1_q[7:4] == 4'b0000
    |=> $stable(timer_output_pin)) else $error("pin moved with no action");
  chk_cmp_level: assert property (quiet && c1_q[7:6] == 2'b00 && c1_q[5] != c1_q[4]
    && timer_output_pin == (c1_q[5] ^ c1_q[2]) |=> $stable(timer_output_pin))
    else $error("pin left requested level");
  chk_unmapped_err: assert property (psel && penable && paddr > `STM_OFS_FLAGS |-> pslverr)
    else $error("unmapped access not refused");
  cover property (quiet && c1_q[7:4] == 4'b1010 && timer_output_pin);
  cover property (c1_q[7:6] == 2'b01 && en_q && $rose(capture_input_pin));
  cover property (wr0 && pwdata[3] && !en_q);
endmodule
bind stm_timer stm_timer_checker i_stm_timer_checker (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .capture_input_pin(capture_input_pin), .timer_output_pin(timer_output_pin),
  .timer_output_pin_oe(timer_output_pin_oe));

// File: tb.sv
// Self-checking testbench for the standard timer
`include "stm_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, cap, pready, pslverr, pin, oe, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [15:0] hi, h0;
  int          err_count, num_checks;
  always #4 pclk = ~pclk;
  stm_timer i_stm_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_input_pin(cap),
    .timer_output_pin(pin), .timer_output_pin_oe(oe));
  stm_load i_stm_load (.pclk(pclk), .pin(pin), .oe(oe), .cap(cap), .hi_cnt(hi));
  // ==========
  // Helpers
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    // Response taken at the access edge itself
    er = pslverr;
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle cycle so a following call never re-drives psel in one step
    @(posedge pclk);
  endtask
  task automatic cfg(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p);
    apb(1, `STM_OFS_CTRL0, 32'h0);
    apb(1, `STM_OFS_CTRL1, {24'h0, c1});
    apb(1, `STM_OFS_CMPA, {16'h0, a});
    apb(1, `STM_OFS_PERIOD, {24'h0, p});
    apb(1, `STM_OFS_FLAGS, 32'h7);
    apb(1, `STM_OFS_CTRL0, 32'h8);
  endtask
  task automatic flags(input logic [1:0] e);
    apb(0, `STM_OFS_FLAGS, 32'h0);
    chk(rd[1:0], e);
  endtask
  // ==========
  // Scenarios
  task automatic t_regs;
    apb(0, `STM_OFS_CTRL1, 32'h0);
    chk(rd, 32'h0);
    apb(0, `STM_OFS_CMPA, 32'h0);
    chk(rd, 32'h0);
    apb(1, `STM_OFS_PERIOD, 32'h5a);
    apb(0, `STM_OFS_PERIOD, 32'h0);
    chk(rd, 32'h5a);
    apb(0, 12'h020, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1, `STM_OFS_CTRL1, 32'hc0);
    repeat (4) @(posedge pclk);
    chk(oe, 1'b0);
    apb(1, `STM_OFS_CTRL1, 32'h0);
    repeat (4) @(posedge pclk);
    chk(oe, 1'b1);
  endtask
  task automatic t_capture;
    for (int a = 0; a < 4; a++) begin
      cfg({2'b01, a[1:0], 4'h0}, 16'h1, 8'h0);
      i_stm_load.set_cap(1'b1);
      repeat (8) @(posedge pclk);
      apb(0, `STM_OFS_FLAGS, 32'h0);
      chk(rd[2], a == 0 || a == 2);
      apb(1, `STM_OFS_FLAGS, 32'h7);
      i_stm_load.set_cap(1'b0);
      repeat (8) @(posedge pclk);
      apb(0, `STM_OFS_FLAGS, 32'h0);
      chk(rd[2], a == 1 || a == 2);
    end
  endtask
  task automatic t_compare;
    cfg(8'h31, 16'h258, 8'h01);
    repeat (1500) @(posedge pclk);
    apb(0, `STM_OFS_CNT, 32'h0);
    chk(rd < 32'h258, 1'b1);
    flags(2'b01);
    cfg(8'h20, 16'h64, 8'h02);
    repeat (1100) @(posedge pclk);
    apb(0, `STM_OFS_CNT, 32'h0);
    chk(rd < 32'h200, 1'b1);
    chk(pin, 1'b1);
    flags(2'b11);
  endtask
  task automatic t_counter;
    apb(1, `STM_OFS_CTRL0, 32'h0);
    apb(0, `STM_OFS_CNT, 32'h0);
    h0 = rd[15:0];
    repeat (20) @(posedge pclk);
    apb(0, `STM_OFS_CNT, 32'h0);
    chk(rd, {16'h0, h0});
    flags(2'b11);
    apb(1, `STM_OFS_FLAGS, 32'h3);
    flags(2'b00);
    apb(1, `STM_OFS_CTRL0, 32'h8);
    apb(0, `STM_OFS_CNT, 32'h0);
    h0 = rd[15:0];
    apb(0, `STM_OFS_CNT, 32'h0);
    chk(rd[15:0] - h0, 16'h3);
    chk(h0 < 16'h8, 1'b1);
  endtask
  task automatic t_pwm;
    logic [7:0]  c1 [7] = '{8'h88, 8'h98, 8'ha8, 8'ha8, 8'haa, 8'hac, 8'hb8};
    logic [15:0] ca [7] = '{16'h40, 16'h40, 16'h40, 16'h12c, 16'h12c, 16'h40, 16'h40};
    logic [15:0] wn [7] = '{16'h200, 16'h200, 16'h200, 16'h200, 16'h258, 16'h200, 16'h200};
    logic [15:0] ex [7] = '{16'h0, 16'h200, 16'h80, 16'h200, 16'h200, 16'h180, 16'h200};
    logic [1:0]  fl [7] = '{2'h3, 2'h3, 2'h3, 2'h2, 2'h3, 2'h3, 2'h3};
    for (int i = 0; i < 7; i++) begin
      cfg(c1[i], ca[i], 8'h01);
      repeat (40) @(posedge pclk);
      h0 = hi;
      repeat (wn[i]) @(posedge pclk);
      chk(hi - h0, ex[i]);
      flags(fl[i]);
    end
  endtask
  task automatic test_done;
    if (err_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========
  // Main sequence and watchdog
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    err_count = 0;
    num_checks = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_capture;
    t_compare;
    t_counter;
    t_pwm;
    test_done;
  end
  initial begin
    repeat (30000) @(posedge pclk);
    err_count++;
    test_done;
  end
endmodule
